// >>> frtc_pkg.sv
// Functional notes
// R1 - Count source: CPU clock /2, /4, /8 or external
// R2 - Both clock-select bits set picks external clock
// R3 - Writing either count low byte reloads FFFCh
// R4 - Reset and reload value is always FFFCh
// R5 - Alternate view equal, low read keeps overflow
// R6 - High read first latches low byte until read
// R7 - Lone low read returns the live low byte
// R8 - Wrap FFFFh to 0000h sets overflow flag
// R9 - Overflow request needs enable and clear mask
// R10 - Overflow clears: status read, then low access
// R11 - Counting continues unchanged in wait state
// R12 - Halt freezes count; reset restarts from FFFCh
// R13 - External edge polarity chosen by select bit
// R14 - External edges at least four CPU clocks apart
// R15 - Capture edge latches counter into channel register
// R16 - Each capture channel has its own edge select
// R17 - Capture sets flag; one enable, masked requests
// R18 - Capture flag clears: status read, then low access
// R19 - Capture high read blocks channel until low read
// R20 - Capture register holds the most recent capture
// R21 - Pulse modes leave only channel two capturing
// R22 - Capture inputs always connected, any edge counts; the code counts only the edge chosen by captureEdgeSelect
// R23 - Unbonded timer pin reads constant one
// R24 - Overflow and capture requests ORed onto one line
package frtc_pkg;

  // Counter values
  localparam logic [15:0] COUNT_RELOAD = 16'hFFFC;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE    = 16'h0001;
  localparam logic [15:0] COUNT_ZERO   = 16'h0000;

  // Clock-select field codes
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT  = 2'h3;

  // Prescaler terminal masks
  localparam logic [2:0] PRESC_MASK2 = 3'h1;
  localparam logic [2:0] PRESC_MASK4 = 3'h3;
  localparam logic [2:0] PRESC_MASK8 = 3'h7;
  localparam logic [2:0] PRESC_ONE   = 3'h1;
  localparam logic [2:0] PRESC_RESET = 3'h0;

  // Status byte bit positions
  localparam int SR_CAP1_BIT = 7;
  localparam int SR_TOF_BIT  = 5;
  localparam int SR_CAP2_BIT = 4;

  // Reset values
  localparam logic [2:0] SYNC_RESET = 3'h7;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;

  // Register access strobes, one cycle each
  typedef struct packed {
    logic       rdCountHigh;
    logic       rdCountLow;
    logic       wrCountLow;
    logic       rdAltHigh;
    logic       rdAltLow;
    logic       wrAltLow;
    logic       rdStatus;
    logic [1:0] rdCapHigh;
    logic [1:0] rdCapLow;
    logic [1:0] wrCapLow;
  } frtc_access_t;

  // Control bits of both control registers
  typedef struct packed {
    logic [1:0] clockSelect;
    logic       extEdgeSelect;
    logic [1:0] captureEdgeSelect;
    logic       overflowIrqEnable;
    logic       captureIrqEnable;
    logic       pulseModeActive;
  } frtc_config_t;

endpackage : frtc_pkg

// >>> frtc_timer.sv
`timescale 1ns/10ps
module frtc_timer #(
  parameter logic EXT_CLK_BONDED = 1'b1,
  parameter logic CAP1_BONDED    = 1'b1,
  parameter logic CAP2_BONDED    = 1'b1
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   extCountClockPin,
  input  wire logic                   captureInputPinOne,
  input  wire logic                   captureInputPinTwo,
  input  wire frtc_pkg::frtc_access_t acc,
  input  wire frtc_pkg::frtc_config_t cfg,
  input  wire logic                   globalIrqMask,
  input  wire logic                   haltMode,
  output logic [7:0]                  readData_r,
  output logic                        readValid_r,
  output logic [15:0]                 countValue_r,
  output logic                        timerOverflowFlag_r,
  output logic [1:0]                  captureFlag_r,
  output logic                        timerIrq_r
);

  // Pin order: bit 0 capture one, bit 1 capture two, bit 2 ext
  logic [2:0]  pinIn;
  logic [2:0]  sync1_r;
  logic [2:0]  sync2_r;
  logic [2:0]  sync3_r;
  logic [2:0]  sync1_nxt;
  logic [2:0]  sync2_nxt;
  logic [2:0]  sync3_nxt;
  logic [2:0]  presc_r;
  logic [2:0]  presc_nxt;
  logic [15:0] count_nxt;
  logic [7:0]  lowLatch_r;
  logic [7:0]  lowLatch_nxt;
  logic        latched_r;
  logic        latched_nxt;
  logic        tofArm_r;
  logic        tofArm_nxt;
  logic        tof_nxt;
  logic [1:0]  capArm_r;
  logic [1:0]  capArm_nxt;
  logic [1:0]  capFlag_nxt;
  logic [1:0]  capInhibit_r;
  logic [1:0]  capInhibit_nxt;
  logic [15:0] capValue_r   [2];
  logic [15:0] capValue_nxt [2];
  logic [7:0]  readData_nxt;
  logic        readValid_nxt;
  logic        irq_nxt;
  logic        tick;
  logic        extEdge;
  logic        countWrite;
  logic        wrapEvent;
  logic        tofClear;
  logic        highRead;
  logic        lowRead;
  logic [1:0]  capEdge;
  logic [1:0]  capEvent;
  logic [1:0]  capLowAccess;
  logic [1:0]  capClear;
  logic [7:0]  statusByte;

  // Unbonded pins are tied high ahead of the synchroniser
  always_comb begin
    pinIn[0] = CAP1_BONDED ? captureInputPinOne : 1'b1; // see R23
    pinIn[1] = CAP2_BONDED ? captureInputPinTwo : 1'b1; // see R23
    pinIn[2] = EXT_CLK_BONDED ? extCountClockPin : 1'b1; // see R23
    sync1_nxt = pinIn;
    sync2_nxt = sync1_r;
    sync3_nxt = sync2_r;
  end

  // Two-stage synchroniser plus an edge history stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_r <= frtc_pkg::SYNC_RESET;
      sync2_r <= frtc_pkg::SYNC_RESET;
      sync3_r <= frtc_pkg::SYNC_RESET;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      sync3_r <= sync3_nxt;
    end
  end

  // Edge detection on synchronised pins; inputs are always live
  always_comb begin
    extEdge = cfg.extEdgeSelect ? (sync2_r[2] & ~sync3_r[2])
                                : (~sync2_r[2] & sync3_r[2]); // see R13
    for (int i = 0; i < 2; i++) begin
      capEdge[i] = cfg.captureEdgeSelect[i]
                 ? (sync2_r[i] & ~sync3_r[i])
                 : (~sync2_r[i] & sync3_r[i]); // see R16, R22
    end
  end

  // Count tick selection; wait state has no input, so no effect
  always_comb begin
    case (cfg.clockSelect)
      frtc_pkg::CLK_DIV2: begin
        tick = (presc_r & frtc_pkg::PRESC_MASK2) ==
               frtc_pkg::PRESC_MASK2; // see R1
      end
      frtc_pkg::CLK_DIV4: begin
        tick = (presc_r & frtc_pkg::PRESC_MASK4) ==
               frtc_pkg::PRESC_MASK4; // see R1
      end
      frtc_pkg::CLK_DIV8: begin
        tick = (presc_r & frtc_pkg::PRESC_MASK8) ==
               frtc_pkg::PRESC_MASK8; // see R1
      end
      default: begin
        tick = extEdge; // see R2, R14
      end
    endcase
    tick = tick & ~haltMode; // see R11, R12
  end

  // Counter, prescaler and overflow detection
  always_comb begin
    countWrite = acc.wrCountLow | acc.wrAltLow;
    wrapEvent  = tick & ~countWrite &
                 (countValue_r == frtc_pkg::COUNT_MAX); // see R8
    presc_nxt  = haltMode ? presc_r : presc_r + frtc_pkg::PRESC_ONE;
    count_nxt  = countValue_r;
    if (countWrite) begin
      count_nxt = frtc_pkg::COUNT_RELOAD; // see R3, R4
    end else if (tick) begin
      count_nxt = countValue_r + frtc_pkg::COUNT_ONE;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      presc_r      <= frtc_pkg::PRESC_RESET;
      countValue_r <= frtc_pkg::COUNT_RELOAD; // see R4, R12
    end else begin
      presc_r      <= presc_nxt;
      countValue_r <= count_nxt;
    end
  end

  // Low byte buffer shared by main and alternate views
  always_comb begin
    highRead     = acc.rdCountHigh | acc.rdAltHigh;
    lowRead      = acc.rdCountLow | acc.rdAltLow;
    lowLatch_nxt = lowLatch_r;
    latched_nxt  = latched_r;
    if (lowRead) begin
      latched_nxt = 1'b0; // see R6
    end else if (highRead && !latched_r) begin
      lowLatch_nxt = countValue_r[7:0]; // see R6
      latched_nxt  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lowLatch_r <= frtc_pkg::BYTE_ZERO;
      latched_r  <= 1'b0;
    end else begin
      lowLatch_r <= lowLatch_nxt;
      latched_r  <= latched_nxt;
    end
  end

  // Flags, capture registers and clearing sequences
  always_comb begin
    tofClear = tofArm_r & (acc.rdCountLow | acc.wrCountLow); // see R5, R10
    tof_nxt  = wrapEvent | (timerOverflowFlag_r & ~tofClear);
    tofArm_nxt = tofArm_r;
    if (acc.rdStatus) begin
      tofArm_nxt = timerOverflowFlag_r; // see R10
    end else if (tofClear) begin
      tofArm_nxt = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      capLowAccess[i] = acc.rdCapLow[i] | acc.wrCapLow[i];
      capEvent[i] = capEdge[i] & ~capInhibit_r[i] &
                    ~(i == 0 && cfg.pulseModeActive); // see R19, R21
      capClear[i] = capArm_r[i] & capLowAccess[i]; // see R18
      capFlag_nxt[i] = capEvent[i] |
                       (captureFlag_r[i] & ~capClear[i]); // see R17
      capValue_nxt[i] = capEvent[i] ? countValue_r
                                    : capValue_r[i]; // see R15, R20
      capArm_nxt[i] = capArm_r[i];
      if (acc.rdStatus) begin
        capArm_nxt[i] = captureFlag_r[i]; // see R18
      end else if (capClear[i]) begin
        capArm_nxt[i] = 1'b0;
      end
      capInhibit_nxt[i] = capInhibit_r[i];
      if (acc.rdCapLow[i]) begin
        capInhibit_nxt[i] = 1'b0; // see R19
      end else if (acc.rdCapHigh[i]) begin
        capInhibit_nxt[i] = 1'b1; // see R19
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timerOverflowFlag_r <= 1'b0;
      tofArm_r            <= 1'b0;
      captureFlag_r       <= 2'h0;
      capArm_r            <= 2'h0;
      capInhibit_r        <= 2'h0;
      capValue_r[0]       <= frtc_pkg::COUNT_ZERO;
      capValue_r[1]       <= frtc_pkg::COUNT_ZERO;
    end else begin
      timerOverflowFlag_r <= tof_nxt;
      tofArm_r            <= tofArm_nxt;
      captureFlag_r       <= capFlag_nxt;
      capArm_r            <= capArm_nxt;
      capInhibit_r        <= capInhibit_nxt;
      capValue_r[0]       <= capValue_nxt[0];
      capValue_r[1]       <= capValue_nxt[1];
    end
  end

  // Read data mux and the combined interrupt request
  always_comb begin
    statusByte = frtc_pkg::BYTE_ZERO;
    statusByte[frtc_pkg::SR_CAP1_BIT] = captureFlag_r[0];
    statusByte[frtc_pkg::SR_TOF_BIT]  = timerOverflowFlag_r;
    statusByte[frtc_pkg::SR_CAP2_BIT] = captureFlag_r[1];
    readValid_nxt = acc.rdStatus | highRead | lowRead |
                    (|acc.rdCapHigh) | (|acc.rdCapLow);
    readData_nxt = frtc_pkg::BYTE_ZERO;
    if (acc.rdStatus) begin
      readData_nxt = statusByte;
    end else if (highRead) begin
      readData_nxt = countValue_r[15:8]; // see R5
    end else if (lowRead) begin
      readData_nxt = latched_r ? lowLatch_r
                               : countValue_r[7:0]; // see R6, R7
    end else if (acc.rdCapHigh[0]) begin
      readData_nxt = capValue_r[0][15:8];
    end else if (acc.rdCapLow[0]) begin
      readData_nxt = capValue_r[0][7:0];
    end else if (acc.rdCapHigh[1]) begin
      readData_nxt = capValue_r[1][15:8];
    end else if (acc.rdCapLow[1]) begin
      readData_nxt = capValue_r[1][7:0];
    end
    irq_nxt = ~globalIrqMask &
              ((timerOverflowFlag_r & cfg.overflowIrqEnable) |
               ((|captureFlag_r) & cfg.captureIrqEnable)); // see R9, R17, R24
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      readData_r  <= frtc_pkg::BYTE_ZERO;
      readValid_r <= 1'b0;
      timerIrq_r  <= 1'b0;
    end else begin
      readData_r  <= readData_nxt;
      readValid_r <= readValid_nxt;
      timerIrq_r  <= irq_nxt;
    end
  end

  // Checks on the behaviour above
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_highThenLow;
    highRead && !latched_r && !lowRead && !acc.rdStatus
    ##1 !highRead && !lowRead
    ##1 lowRead && !highRead && !acc.rdStatus;
  endsequence

  sequence s_statusThenLow;
    acc.rdStatus && timerOverflowFlag_r && !lowRead && !acc.wrCountLow
    ##1 !acc.rdStatus && !acc.rdCountLow && !acc.wrCountLow
    ##1 acc.rdCountLow && !acc.rdStatus && !wrapEvent;
  endsequence

  sequence s_capStatusThenLow;
    acc.rdStatus && captureFlag_r[0] && !capLowAccess[0]
    ##1 !acc.rdStatus && !capLowAccess[0]
    ##1 capLowAccess[0] && !acc.rdStatus && !capEvent[0];
  endsequence

  a_count_reload: assert property ( // see R3
    countWrite |=> countValue_r == frtc_pkg::COUNT_RELOAD
  ) else $error("count not reloaded by low byte write");

  a_wrap_flag: assert property ( // see R8
    tick && !countWrite && countValue_r == frtc_pkg::COUNT_MAX
    |=> countValue_r == frtc_pkg::COUNT_ZERO && timerOverflowFlag_r
  ) else $error("wrap did not set overflow");

  a_div2_rate: assert property ( // see R1
    cfg.clockSelect == frtc_pkg::CLK_DIV2 && !haltMode && !countWrite
    && $stable(cfg) ##1 !haltMode && !countWrite && $stable(cfg)
    |=> countValue_r == $past(countValue_r, 2) + frtc_pkg::COUNT_ONE
  ) else $error("divide by two rate wrong");

  a_alt_keeps_tof: assert property ( // see R5
    timerOverflowFlag_r && acc.rdAltLow && !acc.rdCountLow
    && !acc.wrCountLow |=> timerOverflowFlag_r
  ) else $error("alternate low read cleared overflow");

  a_latch_hold: assert property ( // see R6
    s_highThenLow |=> readData_r == $past(countValue_r[7:0], 3)
  ) else $error("buffered low byte not returned");

  a_live_low: assert property ( // see R7
    lowRead && !latched_r && !acc.rdStatus && !highRead
    |=> readData_r == $past(countValue_r[7:0])
  ) else $error("lone low read not live");

  a_tof_clear: assert property ( // see R10
    s_statusThenLow |=> !timerOverflowFlag_r
  ) else $error("overflow not cleared by sequence");

  a_irq_masked: assert property ( // see R9
    globalIrqMask |=> !timerIrq_r
  ) else $error("request while globally masked");

  a_halt_freeze: assert property ( // see R12
    haltMode && !countWrite |=> $stable(countValue_r)
  ) else $error("counter moved in halt");

  a_cap_latch: assert property ( // see R15
    capEvent[1] |=> capValue_r[1] == $past(countValue_r)
                    && captureFlag_r[1]
  ) else $error("capture two not latched");

  a_cap_inhibit: assert property ( // see R19
    capInhibit_r[1] && !acc.rdCapLow[1] |=> $stable(capValue_r[1])
  ) else $error("capture two changed while blocked");

  a_pulse_ch1_off: assert property ( // see R21
    cfg.pulseModeActive |=> $stable(capValue_r[0])
  ) else $error("channel one captured in pulse mode");

  a_cap_clear: assert property ( // see R18
    s_capStatusThenLow |=> !captureFlag_r[0]
  ) else $error("capture one not cleared by sequence");

  a_irq_request: assert property ( // see R9, R24
    !globalIrqMask && timerOverflowFlag_r && cfg.overflowIrqEnable
    |=> timerIrq_r
  ) else $error("pending overflow request not raised");

endmodule : frtc_timer

// >>> frtc_pin_model.sv
`timescale 1ns/10ps
module frtc_pin_model (
  input  wire logic clk_sys,
  output logic      extPin,
  output logic      capOne,
  output logic      capTwo
);
  // Pins rest high, as pulled-up lines do
  initial begin
    extPin = 1'b1;
    capOne = 1'b1;
    capTwo = 1'b1;
  end

  // Moves one pin after a falling edge, then holds it five cycles
  task automatic drive(input int pin, input logic lvl);
    @(negedge clk_sys);
    case (pin)
      0: extPin = lvl;
      1: capOne = lvl;
      default: capTwo = lvl;
    endcase
    repeat (5) @(negedge clk_sys);
  endtask : drive

  // Low then high again: one edge of each polarity
  task automatic pulse(input int pin);
    drive(pin, 1'b0);
    drive(pin, 1'b1);
  endtask : pulse
endmodule : frtc_pin_model

// >>> frtc_timer_test.sv
`timescale 1ns/10ps
module frtc_timer_test;
  // Strobe patterns in the bit order of the access struct
  localparam logic [12:0] RD_CH  = 13'h1000;
  localparam logic [12:0] RD_CL  = 13'h0800;
  localparam logic [12:0] WR_CL  = 13'h0400;
  localparam logic [12:0] RD_AH  = 13'h0200;
  localparam logic [12:0] RD_AL  = 13'h0100;
  localparam logic [12:0] WR_AL  = 13'h0080;
  localparam logic [12:0] RD_ST  = 13'h0040;
  localparam logic [12:0] RD_K1H = 13'h0010;
  localparam logic [12:0] RD_K2H = 13'h0020;
  localparam logic [12:0] RD_K1L = 13'h0004;
  localparam logic [12:0] RD_K2L = 13'h0008;
  localparam logic [12:0] WR_K1L = 13'h0001;
  localparam logic [12:0] WR_K2L = 13'h0002;
  localparam logic [12:0] RD_ALL = 13'h1B7C;
  localparam logic [1:0]  CODES [3] = '{frtc_pkg::CLK_DIV2,
    frtc_pkg::CLK_DIV4, frtc_pkg::CLK_DIV8};

  logic                   clk_sys;
  logic                   rst;
  logic                   globalIrqMask;
  logic                   haltMode;
  frtc_pkg::frtc_access_t acc;
  frtc_pkg::frtc_config_t cfg;
  logic                   extPin;
  logic                   capOne;
  logic                   capTwo;
  logic [7:0]             readData_r;
  logic                   readValid_r;
  logic [15:0]            countValue_r;
  logic                   timerOverflowFlag_r;
  logic [1:0]             captureFlag_r;
  logic                   timerIrq_r;
  int                     errors;
  int                     samples_checked;

  frtc_pin_model pins (
    .clk_sys (clk_sys),
    .extPin  (extPin),
    .capOne  (capOne),
    .capTwo  (capTwo)
  );

  frtc_timer dut (
    .clk_sys             (clk_sys),
    .rst                 (rst),
    .extCountClockPin    (extPin),
    .captureInputPinOne  (capOne),
    .captureInputPinTwo  (capTwo),
    .acc                 (acc),
    .cfg                 (cfg),
    .globalIrqMask       (globalIrqMask),
    .haltMode            (haltMode),
    .readData_r          (readData_r),
    .readValid_r         (readValid_r),
    .countValue_r        (countValue_r),
    .timerOverflowFlag_r (timerOverflowFlag_r),
    .captureFlag_r       (captureFlag_r),
    .timerIrq_r          (timerIrq_r)
  );

  // System clock, 10 ns period
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle strobe; answer is judged the cycle after
  task automatic access(input logic [12:0] s);
    @(negedge clk_sys);
    acc = frtc_pkg::frtc_access_t'(s);
    @(negedge clk_sys);
    acc = '0;
    check({15'h0, readValid_r}, {15'h0, |(s & RD_ALL)});
  endtask : access

  task automatic rd(input logic [12:0] s, input logic [7:0] exp);
    access(s);
    check({8'h00, readData_r}, {8'h00, exp});
  endtask : rd

  task automatic flags(input logic [2:0] exp);
    check({13'h0, timerOverflowFlag_r, captureFlag_r}, {13'h0, exp});
  endtask : flags

  task automatic irq(input logic exp);
    repeat (3) @(negedge clk_sys);
    check({15'h0, timerIrq_r}, {15'h0, exp});
  endtask : irq

  // External clock, edge choice and reloads
  task automatic testExtClock;
    pins.drive(0, 1'b0);
    check(countValue_r, 16'hFFFC);
    pins.drive(0, 1'b1);
    check(countValue_r, 16'hFFFD);
    cfg.extEdgeSelect = 1'b0;
    pins.pulse(0);
    check(countValue_r, 16'hFFFE);
    access(WR_AL);
    check(countValue_r, frtc_pkg::COUNT_RELOAD);
    pins.pulse(0);
    access(WR_CL);
    check(countValue_r, frtc_pkg::COUNT_RELOAD);
  endtask : testExtClock

  task automatic testReadSeq;
    pins.pulse(0);
    rd(RD_CH, 8'hFF);
    pins.pulse(0);
    pins.pulse(0);
    rd(RD_CH, 8'hFF);
    rd(RD_AL, 8'hFD);
    rd(RD_CL, 8'hFF);
    rd(RD_AH, 8'hFF);
    rd(RD_AL, 8'hFF);
  endtask : testReadSeq

  task automatic testOverflow;
    cfg.overflowIrqEnable = 1'b1;
    pins.pulse(0);
    check(countValue_r, frtc_pkg::COUNT_ZERO);
    flags(3'h4);
    irq(1'b0);
    globalIrqMask = 1'b0;
    irq(1'b1);
    rd(RD_CL, 8'h00);
    flags(3'h4);
    rd(RD_ST, 8'h20);
    rd(RD_AL, 8'h00);
    flags(3'h4);
    rd(RD_ST, 8'h20);
    rd(RD_CL, 8'h00);
    flags(3'h0);
    irq(1'b0);
    cfg.overflowIrqEnable = 1'b0;
  endtask : testOverflow

  task automatic testCapture;
    cfg.captureEdgeSelect = 2'b01;
    cfg.captureIrqEnable = 1'b1;
    pins.pulse(0);
    pins.drive(1, 1'b0);
    flags(3'h0);
    pins.drive(1, 1'b1);
    flags(3'h1);
    irq(1'b1);
    pins.pulse(0);
    pins.pulse(1);
    rd(RD_ST, 8'h80);
    rd(RD_K1H, 8'h00);
    pins.pulse(0);
    pins.pulse(1);
    rd(RD_K1L, 8'h02);
    flags(3'h0);
    pins.drive(2, 1'b0);
    flags(3'h2);
    pins.drive(2, 1'b1);
    rd(RD_K2H, 8'h00);
    rd(RD_K2L, 8'h03);
    rd(RD_ST, 8'h10);
    rd(RD_K2L, 8'h03);
    flags(3'h0);
    cfg.pulseModeActive = 1'b1;
    pins.pulse(1);
    flags(3'h0);
    pins.pulse(2);
    flags(3'h2);
    globalIrqMask = 1'b1;
    irq(1'b0);
    cfg.pulseModeActive = 1'b0;
  endtask : testCapture

  // Swapped edge choice and clearing by capture low writes
  task automatic testCapEdges;
    cfg.captureEdgeSelect = 2'b10;
    rd(RD_ST, 8'h10);
    access(WR_K2L);
    flags(3'h0);
    pins.pulse(0);
    pins.drive(1, 1'b0);
    flags(3'h1);
    pins.drive(1, 1'b1);
    pins.drive(2, 1'b0);
    flags(3'h1);
    pins.drive(2, 1'b1);
    flags(3'h3);
    rd(RD_ST, 8'h90);
    access(WR_K1L);
    flags(3'h2);
    rd(RD_K2L, 8'h04);
    flags(3'h0);
    rd(RD_K1H, 8'h00);
    rd(RD_K1L, 8'h04);
  endtask : testCapEdges

  // Halt left through a reset restarts from the reload value
  task automatic testResetWake;
    haltMode = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(countValue_r, frtc_pkg::COUNT_RELOAD);
    flags(3'h0);
    haltMode = 1'b0;
    rst = 1'b0;
    repeat (16) @(negedge clk_sys);
    check(countValue_r, 16'hFFFE);
  endtask : testResetWake

  task automatic testPrescale;
    logic [15:0] c0;
    for (int i = 0; i < 3; i++) begin
      cfg.clockSelect = CODES[i];
      repeat (8) @(negedge clk_sys);
      c0 = countValue_r;
      repeat (16) @(negedge clk_sys);
      check(countValue_r - c0, 16'(16 >> (i + 1)));
    end
    haltMode = 1'b1;
    repeat (2) @(negedge clk_sys);
    c0 = countValue_r;
    repeat (16) @(negedge clk_sys);
    check(countValue_r, c0);
    haltMode = 1'b0;
    repeat (16) @(negedge clk_sys);
    check(countValue_r - c0, 16'h0002);
  endtask : testPrescale

  task automatic print_verdict;
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // Watchdog against a hang
  initial begin
    #200us;
    errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    errors = 0;
    samples_checked = 0;
    rst = 1'b1;
    acc = '0;
    cfg = '0;
    cfg.clockSelect = frtc_pkg::CLK_EXT;
    cfg.extEdgeSelect = 1'b1;
    globalIrqMask = 1'b1;
    haltMode = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(countValue_r, frtc_pkg::COUNT_RELOAD);
    flags(3'h0);
    rst = 1'b0;
    testExtClock();
    testReadSeq();
    testOverflow();
    testCapture();
    testCapEdges();
    testPrescale();
    testResetWake();
    print_verdict();
  end
endmodule : frtc_timer_test
